// file: include/fifo_flags_pkg.sv
// constants, types and field layouts for the dual-clock fifo with flags and retransmit
//
// Summary of operation
// - write past half depth drives half-full low
// - read to half or less releases half-full
// - standard timing: half-full after half plus one
// - depth 131072 words, 262144 when both narrow
// - show-ahead depth counts the output register
// - half-full set by writes, cleared by reads
// - eighteen-bit output, or low nine bits
// - wide-to-wide: big keeps bytes, little swaps
// - empty flag clears one read cycle later
// - full flag clears one write cycle later
// - show-ahead: output-ready two read cycles later
// - almost-empty clears one read cycle later
// - show-ahead: input-ready one write cycle later
// - almost-full clears one write cycle later
// - retransmit mode sampled during master reset
// - low mode: empty queue updates flag immediately
// - low mode gives zero-latency retransmit
// - full flag low at full depth, blocks writes
`default_nettype none

package fifo_flags_pkg;

  // ------------------------------------------------------------------
  // storage geometry
  // ------------------------------------------------------------------
  localparam int unsigned MEM_BYTES  = 262144;
  localparam int unsigned PTR_W      = 19;
  localparam int unsigned IDX_W      = 18;
  localparam logic [18:0] HALF_BYTES = 19'h20000;
  localparam logic [18:0] FULL_BYTES = 19'h40000;

  // ------------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS  = 8'h00;
  localparam logic [7:0]  ADDR_FILL    = 8'h04;
  localparam logic [7:0]  ADDR_AE_OFF  = 8'h08;
  localparam logic [7:0]  ADDR_AF_OFF  = 8'h0C;
  localparam logic [7:0]  ADDR_CONFIG  = 8'h10;
  localparam logic [18:0] AE_OFF_RST   = 19'h0007F;
  localparam logic [18:0] AF_OFF_RST   = 19'h0007F;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int unsigned SYNC_W       = 31;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        wclk;
    logic        rclk;
    logic        write_enable_n;
    logic        read_enable_n;
    logic        retransmit_n;
    logic        master_reset_n;
    logic        partial_reset_n;
    logic        output_enable_n;
    logic        retransmit_mode_select;
    logic        big_endian_select;
    logic        input_width_select;
    logic        output_width_select;
    logic        show_ahead_timing;
    logic [17:0] data_in;
  } pin_bundle_t;

  typedef struct packed {
    logic rt_normal;
    logic big_endian;
    logic in_narrow;
    logic out_narrow;
    logic show_ahead;
  } cfg_t;

  localparam cfg_t CFG_RST = 5'h00;

  typedef enum logic [1:0] {
    RT_IDLE   = 2'b00,
    RT_SETUP  = 2'b01,
    RT_RELOAD = 2'b11
  } rt_state_t;

endpackage : fifo_flags_pkg

`default_nettype wire

// file: src/fifo_flags_core.sv
// dual-clock fifo: pointers, flags, byte matching, retransmit and register slave
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`default_nettype none

module fifo_flags_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wclk,
  input  wire logic        rclk,
  input  wire logic        write_enable_n,
  input  wire logic        read_enable_n,
  input  wire logic        retransmit_n,
  input  wire logic        master_reset_n,
  input  wire logic        partial_reset_n,
  input  wire logic        output_enable_n,
  input  wire logic        retransmit_mode_select,
  input  wire logic        big_endian_select,
  input  wire logic        input_width_select,
  input  wire logic        output_width_select,
  input  wire logic        show_ahead_timing,
  input  wire logic [17:0] data_in,
  output var  logic [17:0] data_out,
  output var  logic        data_out_en,
  output var  logic        full_flag_n,
  output var  logic        input_ready_n,
  output var  logic        empty_flag_n,
  output var  logic        output_ready_n,
  output var  logic        half_full_n,
  output var  logic        almost_empty_n,
  output var  logic        almost_full_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ------------------------------------------------------------------
  // pin sampling and clock edge detection
  // ------------------------------------------------------------------
  fifo_flags_pkg::pin_bundle_t pins_raw;
  fifo_flags_pkg::pin_bundle_t pins;
  logic                        wclk_q_r;
  logic                        rclk_q_r;
  logic                        w_edge;
  logic                        r_edge;

  assign pins_raw = {wclk, rclk, write_enable_n, read_enable_n, retransmit_n, master_reset_n,
                     partial_reset_n, output_enable_n, retransmit_mode_select, big_endian_select,
                     input_width_select, output_width_select, show_ahead_timing, data_in};

  pin_sync #(.W(fifo_flags_pkg::SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pins_raw),
    .dout    (pins)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wclk_q_r <= 1'b0;
      rclk_q_r <= 1'b0;
    end else begin
      wclk_q_r <= pins.wclk;
      rclk_q_r <= pins.rclk;
    end
  end

  assign w_edge = pins.wclk & ~wclk_q_r;
  assign r_edge = pins.rclk & ~rclk_q_r;

  // ------------------------------------------------------------------
  // configuration latched at master reset
  // ------------------------------------------------------------------
  fifo_flags_pkg::cfg_t cfg_r;
  logic                 in_rst;

  assign in_rst = ~pins.master_reset_n | ~pins.partial_reset_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= fifo_flags_pkg::CFG_RST;
    end else if (!pins.master_reset_n) begin
      cfg_r <= {pins.retransmit_mode_select, pins.big_endian_select, pins.input_width_select,
                pins.output_width_select, pins.show_ahead_timing};
    end
  end

  // ------------------------------------------------------------------
  // fill arithmetic in bytes, depth_words in words
  // ------------------------------------------------------------------
  function automatic logic [18:0] to_words(input logic [18:0] bytes, input logic both_narrow);
    to_words = both_narrow ? bytes : {1'b0, bytes[18:1]};
  endfunction : to_words

  logic [8:0]   mem9 [fifo_flags_pkg::MEM_BYTES];
  logic [18:0]  wptr_r;
  logic [18:0]  rptr_r;
  logic [18:0]  wptr_nxt;
  logic [18:0]  rptr_nxt;
  logic [18:0]  mem_bytes;
  logic [18:0]  mem_nxt;
  logic [18:0]  tot_nxt;
  logic [18:0]  in_b;
  logic [18:0]  out_b;
  logic [18:0]  hf_lim;
  logic [18:0]  depth_words;
  logic         both_narrow;
  logic         full_r;
  logic         rdy_r;
  logic         outv_r;
  logic         outv_nxt;
  logic         stage1_r;
  logic         hf_r;
  logic         ae_r;
  logic         af_r;
  logic [18:0]  ae_off_r;
  logic [18:0]  af_off_r;
  logic         wr_ev;
  logic         rd_std;
  logic         consume;
  logic         load;
  logic         rt_ev;
  logic         rt_zero;
  logic [17:0]  rd_idx;
  logic [8:0]   b0;
  logic [8:0]   b1;
  fifo_flags_pkg::rt_state_t rt_state_r;

  assign both_narrow = cfg_r.in_narrow & cfg_r.out_narrow;
  assign in_b        = cfg_r.in_narrow ? 19'h00001 : 19'h00002;
  assign out_b       = cfg_r.out_narrow ? 19'h00001 : 19'h00002;
  assign mem_bytes   = wptr_r - rptr_r;
  // show-ahead adds the output register to depth and to the half mark
  assign hf_lim      = cfg_r.show_ahead ? fifo_flags_pkg::HALF_BYTES + out_b : fifo_flags_pkg::HALF_BYTES;
  assign depth_words = to_words(fifo_flags_pkg::FULL_BYTES, both_narrow) + {18'h0, cfg_r.show_ahead};

  // writes are refused once the store has no room for one more input word
  assign wr_ev   = w_edge & ~pins.write_enable_n & ~full_r & ~in_rst;
  assign rt_ev   = r_edge & ~pins.retransmit_n & ~in_rst;
  assign rt_zero = rt_ev & ~cfg_r.rt_normal;
  assign rd_std  = r_edge & ~cfg_r.show_ahead & ~pins.read_enable_n & rdy_r & ~rt_ev
                   & (rt_state_r == fifo_flags_pkg::RT_IDLE) & ~in_rst;
  assign consume = r_edge & cfg_r.show_ahead & ~pins.read_enable_n & outv_r & ~rt_ev & ~in_rst;
  // a word is shifted out one read edge after the store was seen non-empty
  assign load    = r_edge & cfg_r.show_ahead & stage1_r & (mem_bytes >= out_b) & (~outv_r | consume)
                   & ~rt_ev & ~in_rst;

  assign wptr_nxt = wr_ev ? wptr_r + in_b : wptr_r;
  assign rptr_nxt = rt_zero ? out_b : (rt_ev ? 19'h00000 : ((rd_std | load) ? rptr_r + out_b : rptr_r));
  assign outv_nxt = rt_zero ? cfg_r.show_ahead : (rt_ev ? 1'b0 : (load | (outv_r & ~consume)));
  assign mem_nxt  = wptr_nxt - rptr_nxt;
  assign tot_nxt  = mem_nxt + ((cfg_r.show_ahead & outv_nxt) ? out_b : 19'h00000);

  // wide-in, narrow-out little endian fetches the second byte first
  assign rd_idx = (rt_zero ? 18'h00000 : rptr_r[17:0])
                  ^ {17'h0, ~cfg_r.big_endian & ~cfg_r.in_narrow & cfg_r.out_narrow};
  assign b0     = mem9[rd_idx];
  assign b1     = mem9[rd_idx + 18'h00001];

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // wide words are kept as two bytes, upper first, so every width mix shares one array
  always_ff @(posedge aclk) begin
    if (wr_ev) begin
      if (cfg_r.in_narrow) begin
        mem9[wptr_r[17:0]] <= pins.data_in[8:0];
      end else begin
        mem9[wptr_r[17:0]]             <= pins.data_in[17:9];
        mem9[wptr_r[17:0] + 18'h00001] <= pins.data_in[8:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || in_rst) begin
      wptr_r <= 19'h00000;
      rptr_r <= 19'h00000;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // ------------------------------------------------------------------
  // data output
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.master_reset_n) begin
      data_out <= 18'h00000;
    end else if (rd_std || load || rt_zero) begin
      if (cfg_r.out_narrow) begin
        data_out <= {9'h000, b0};
      end else begin
        data_out <= cfg_r.big_endian ? {b0, b1} : {b1, b0};
      end
    end
  end

  assign data_out_en = ~pins.output_enable_n;

  // ------------------------------------------------------------------
  // write-side flags
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || in_rst) begin
      full_r <= 1'b0;
      af_r   <= 1'b0;
    end else if (w_edge) begin
      full_r <= (fifo_flags_pkg::FULL_BYTES - mem_nxt) < in_b;
      af_r   <= to_words(tot_nxt, both_narrow) >= depth_words - af_off_r;
    end
  end

  // ------------------------------------------------------------------
  // read-side flags and retransmit sequence
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || in_rst) begin
      rdy_r      <= 1'b0;
      outv_r     <= 1'b0;
      stage1_r   <= 1'b0;
      ae_r       <= 1'b1;
      rt_state_r <= fifo_flags_pkg::RT_IDLE;
    end else if (r_edge) begin
      outv_r   <= outv_nxt;
      stage1_r <= ~rt_ev & (mem_nxt >= out_b);
      ae_r     <= to_words(tot_nxt, both_narrow) <= ae_off_r + {18'h0, cfg_r.show_ahead};
      if (rt_zero) begin
        rdy_r <= 1'b1;
      end else if (rt_ev) begin
        rdy_r      <= 1'b0;
        rt_state_r <= fifo_flags_pkg::RT_SETUP;
      end else begin
        rdy_r <= mem_nxt >= out_b;
        case (rt_state_r)
          fifo_flags_pkg::RT_SETUP: begin
            rt_state_r <= cfg_r.show_ahead ? fifo_flags_pkg::RT_RELOAD : fifo_flags_pkg::RT_IDLE;
          end
          fifo_flags_pkg::RT_RELOAD: begin
            if (outv_nxt) begin
              rt_state_r <= fifo_flags_pkg::RT_IDLE;
            end
          end
          default: begin
            rt_state_r <= fifo_flags_pkg::RT_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // half-full: set on write edges, cleared on read edges
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || in_rst) begin
      hf_r <= 1'b0;
    end else if (w_edge && tot_nxt > hf_lim) begin
      hf_r <= 1'b1;
    end else if (r_edge && tot_nxt <= hf_lim) begin
      hf_r <= 1'b0;
    end
  end

  assign full_flag_n    = ~full_r;
  assign input_ready_n  = full_r;
  assign empty_flag_n   = rdy_r;
  assign output_ready_n = ~outv_r;
  assign half_full_n    = ~hf_r;
  assign almost_empty_n = ~ae_r;
  assign almost_full_n  = ~af_r;

  // ------------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // offsets stay across partial reset, only master reset or aresetn restores them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fifo_flags_pkg::RESP_OKAY;
      ae_off_r     <= fifo_flags_pkg::AE_OFF_RST;
      af_off_r     <= fifo_flags_pkg::AF_OFF_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (aw_held_r && w_held_r) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= fifo_flags_pkg::RESP_OKAY;
        if (awaddr_r == fifo_flags_pkg::ADDR_AE_OFF) begin
          ae_off_r <= wdata_r[18:0];
        end else if (awaddr_r == fifo_flags_pkg::ADDR_AF_OFF) begin
          af_off_r <= wdata_r[18:0];
        end else if (awaddr_r != fifo_flags_pkg::ADDR_STATUS && awaddr_r != fifo_flags_pkg::ADDR_FILL
                     && awaddr_r != fifo_flags_pkg::ADDR_CONFIG) begin
          s_axi_bresp <= fifo_flags_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (!pins.master_reset_n) begin
        ae_off_r <= fifo_flags_pkg::AE_OFF_RST;
        af_off_r <= fifo_flags_pkg::AF_OFF_RST;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= fifo_flags_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= fifo_flags_pkg::RESP_OKAY;
      if (s_axi_araddr == fifo_flags_pkg::ADDR_STATUS) begin
        s_axi_rdata <= {24'h000000, (rt_state_r != fifo_flags_pkg::RT_IDLE), af_r, ae_r, hf_r,
                        outv_r, rdy_r, full_r, in_rst};
      end else if (s_axi_araddr == fifo_flags_pkg::ADDR_FILL) begin
        s_axi_rdata <= {13'h0000, to_words(mem_bytes, both_narrow)};
      end else if (s_axi_araddr == fifo_flags_pkg::ADDR_AE_OFF) begin
        s_axi_rdata <= {13'h0000, ae_off_r};
      end else if (s_axi_araddr == fifo_flags_pkg::ADDR_AF_OFF) begin
        s_axi_rdata <= {13'h0000, af_off_r};
      end else if (s_axi_araddr == fifo_flags_pkg::ADDR_CONFIG) begin
        s_axi_rdata <= {27'h0000000, cfg_r};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= fifo_flags_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hf_set_write: assert property (wr_ev && !r_edge && tot_nxt > hf_lim |=> hf_r)
    else $error("half-full not set by filling write");
  a_hf_clear_read: assert property ($fell(hf_r) |-> $past(r_edge) || $past(in_rst))
    else $error("half-full cleared off a read edge");
  a_hf_rise_write: assert property ($rose(hf_r) |-> $past(w_edge) && $past(tot_nxt) > $past(hf_lim))
    else $error("half-full set without crossing the mark");
  a_narrow_out_zero: assert property (cfg_r.out_narrow && (rd_std || load) |=> data_out[17:9] == 9'h000)
    else $error("narrow output drives upper byte");
  a_wide_byte_order: assert property (rd_std && !cfg_r.out_narrow && !cfg_r.big_endian
                                      |=> data_out[8:0] == $past(b0))
    else $error("little endian bytes not swapped");
  a_empty_clear_edge: assert property ($rose(rdy_r) |-> $past(r_edge))
    else $error("empty flag moved off a read edge");
  a_full_clear_edge: assert property ($fell(full_r) |-> $past(w_edge) || $past(in_rst))
    else $error("full flag moved off a write edge");
  a_ready_two_stage: assert property ($rose(outv_r) && !$past(rt_zero) |-> $past(stage1_r))
    else $error("output ready without staged fill");
  a_ae_clear_read: assert property ($fell(ae_r) |-> $past(r_edge))
    else $error("almost-empty cleared off a read edge");
  a_af_clear_write: assert property ($fell(af_r) |-> $past(w_edge) || $past(in_rst))
    else $error("almost-full cleared off a write edge");
  a_mode_latch: assert property (!pins.master_reset_n |=> cfg_r.rt_normal == $past(pins.retransmit_mode_select))
    else $error("retransmit mode not latched in reset");
  a_zero_lat_rt: assert property (rt_zero |=> (cfg_r.show_ahead ? outv_r : rdy_r) && rptr_r == $past(out_b))
    else $error("zero latency retransmit did not present data");
  a_full_blocks: assert property (full_r && !in_rst |=> wptr_r == $past(wptr_r))
    else $error("write accepted while full");

  c_half_full: cover property ($rose(hf_r));
  c_full: cover property ($rose(full_r));
  c_rt_normal: cover property (rt_ev && cfg_r.rt_normal ##[1:200] rt_state_r == fifo_flags_pkg::RT_IDLE);
  c_show_ahead: cover property (load && cfg_r.show_ahead);

endmodule : fifo_flags_core

`default_nettype wire

// file: src/pin_sync.sv
// two-flop synchroniser for the pin bundle sampled by aclk
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: verif/dual_clock_fifo_flags_retransmit_tb.sv
// self-checking bench: pin transfers, byte order, retransmit, register reads
`default_nettype none
module dual_clock_fifo_flags_retransmit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, wclk, rclk, write_enable_n, read_enable_n, retransmit_n, master_reset_n, partial_reset_n;
  logic output_enable_n, retransmit_mode_select, big_endian_select, input_width_select, output_width_select;
  logic show_ahead_timing, data_out_en, full_flag_n, input_ready_n, empty_flag_n, output_ready_n, half_full_n;
  logic almost_empty_n, almost_full_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] data_in, data_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_mismatch = 0;
  int          tests_run = 0;
  fifo_flags_core i_fifo_flags_core (.*);
  fifo_pins_model i_fifo_pins_model (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ------------------------------------------------------------
  // checking and register bus tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 50) begin
      n_mismatch++;
      test_done;
    end
  endtask : hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (!tb && n < 50);
    s_axi_bready <= 1'b0;
    hang(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tv;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      {ta, tv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (!tv && n < 50);
    s_axi_rready <= 1'b0;
    hang(n);
  endtask : axi_rd
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [17:0] w1, w2;
    logic [17:0] e [2];
    w1 = 18'h2A955;
    w2 = 18'h1C0F3;
    {aresetn, partial_reset_n, master_reset_n, output_enable_n, retransmit_mode_select} = 5'h0D;
    {big_endian_select, input_width_select, output_width_select, show_ahead_timing} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      big_endian_select      <= (i != 1);
      output_width_select    <= (i == 2);
      show_ahead_timing      <= (i == 3);
      retransmit_mode_select <= (i != 3);
      master_reset_n      <= 1'b0;
      repeat (20) @(posedge aclk);
      master_reset_n <= 1'b1;
      repeat (6) @(posedge aclk);
      #1;
      chk(empty_flag_n, 1'b0);
      axi_rd(fifo_flags_pkg::ADDR_CONFIG, d, r);
      chk(d, {27'h0, i != 3, i != 1, 1'b0, i == 2, i == 3});
      // two writes stay far below the almost-full mark at depth minus 127
      i_fifo_pins_model.wr(w1);
      i_fifo_pins_model.wr(w2);
      i_fifo_pins_model.rd(1'b1, 1'b1);
      chk(empty_flag_n, 1'b1);
      chk(half_full_n, 1'b1);
      chk({full_flag_n, input_ready_n, almost_empty_n, almost_full_n}, 32'h00000009);
      chk(data_out_en, 1'b1);
      e[0] = (i == 1) ? {w1[8:0], w1[17:9]} : (i == 2) ? {9'h000, w1[17:9]} : w1;
      e[1] = (i == 1) ? {w2[8:0], w2[17:9]} : (i == 2) ? {9'h000, w1[8:0]} : w2;
      for (int j = 0; j < 2; j++) begin
        i_fifo_pins_model.rd(1'b0, 1'b1);
        chk(data_out, e[j]);
      end
      if (i == 0) begin
        i_fifo_pins_model.rd(1'b1, 1'b0);
        chk(empty_flag_n, 1'b0);
        i_fifo_pins_model.rd(1'b1, 1'b1);
        chk(empty_flag_n, 1'b1);
        i_fifo_pins_model.rd(1'b0, 1'b1);
        chk(data_out, w1);
      end else if (i == 3) begin
        i_fifo_pins_model.rd(1'b1, 1'b0);
        chk(data_out, w1);
        chk(output_ready_n, 1'b0);
      end
      $display("test %0d done", i);
    end
    partial_reset_n <= 1'b0;
    repeat (20) @(posedge aclk);
    partial_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
    #1;
    chk(output_ready_n, 1'b1);
    axi_rd(fifo_flags_pkg::ADDR_CONFIG, d, r);
    chk(d, 32'h00000009);
    $display("test partial reset done");
    axi_wr(fifo_flags_pkg::ADDR_AE_OFF, 32'h00000155, r);
    chk(r, fifo_flags_pkg::RESP_OKAY);
    axi_rd(fifo_flags_pkg::ADDR_AE_OFF, d, r);
    chk(d, 32'h00000155);
    axi_rd(8'h20, d, r);
    chk(r, fifo_flags_pkg::RESP_SLVERR);
    $display("test register bus done");
    test_done;
  end
endmodule : dual_clock_fifo_flags_retransmit_tb
`default_nettype wire

// file: verif/fifo_pins_model.sv
// writer and reader pin model on slow link clocks
`default_nettype none
module fifo_pins_model (
  input  wire logic        aclk,
  output var  logic        wclk,
  output var  logic        rclk,
  output var  logic        write_enable_n,
  output var  logic        read_enable_n,
  output var  logic        retransmit_n,
  output var  logic [17:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  bit odd_r;
  initial begin
    {wclk, rclk, odd_r} = 3'h0;
    {write_enable_n, read_enable_n, retransmit_n} = 3'h7;
    data_in = 18'h00000;
  end
  // clocks stand still between transfers; low phase alternates 6/7 for 125 ns mean period
  task automatic pulse(input bit is_wr);
    repeat (6 + int'(odd_r)) @(posedge aclk);
    odd_r = !odd_r;
    if (is_wr) wclk <= 1'b1; else rclk <= 1'b1;
    repeat (6) @(posedge aclk);
    if (is_wr) wclk <= 1'b0; else rclk <= 1'b0;
  endtask : pulse
  task automatic wr(input logic [17:0] d);
    write_enable_n <= 1'b0;
    data_in        <= d;
    pulse(1'b1);
    write_enable_n <= 1'b1;
    data_in        <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic ren_n, input logic rt_n);
    read_enable_n <= ren_n;
    retransmit_n  <= rt_n;
    pulse(1'b0);
    read_enable_n <= 1'b1;
    retransmit_n  <= 1'b1;
    #1;
  endtask : rd
endmodule : fifo_pins_model
`default_nettype wire
